// ### common/foldback_consts.vh
`ifndef FOLDBACK_CONSTS_VH
`define FOLDBACK_CONSTS_VH
// ------------------------------------------------------------
// register offsets (direct register map)
// ------------------------------------------------------------
`define OFS_OPERATING_MODE_CONTROL 8'h25
`define OFS_HOST_INTERFACE_CONTROL 8'h26
`define OFS_SEQUENCER_CONTROL      8'h27
`define OFS_INDIRECT_ADDRESS       8'h2B
`define OFS_INDIRECT_DATA          8'h2C
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_OPERATING_MODE_CONTROL 16'h8040
`define RST_HOST_INTERFACE_CONTROL 16'h0000
`define RST_SEQUENCER_CONTROL      16'h0003
`define RST_INDIRECT_ADDRESS       8'h00
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_MODE_PIN_DISABLE       13
`define BIT_SEQUENCER_OWNS_IO      6
`define BIT_I2C_TIMEOUT_ENABLE     12
`define BIT_FAST_SERIAL_OUT_ENABLE 2
`define BIT_SERIAL_OUT_ENABLE      0
`define BIT_SEQUENCER_ABORT        2
`define BIT_SEQUENCER_RUN          1
`define BIT_SEQUENCER_ENABLE       0
// writable masks: reserved r/w fields keep their bits, don't-care bits are dropped
`define MASK_OPERATING_MODE_CONTROL 16'hFFFF
`define MASK_HOST_INTERFACE_CONTROL 16'h1005
`define MASK_SEQUENCER_CONTROL      16'hFFFF
// ------------------------------------------------------------
// parameter memory layout
// ------------------------------------------------------------
`define PMEM_X1 8'h20
`define PMEM_Y1 8'h21
`define PMEM_X2 8'h22
`define PMEM_Y2 8'h23
`define PMEM_X3 8'h24
`define PMEM_Y3 8'h25
`define PMEM_X_MASK 16'h07FE
`define PMEM_Y_MASK 16'h00FF
`endif

// ### src/foldback_config_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "foldback_consts.vh"
module foldback_config_regs (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        wr_en_in,
  input  wire        rd_en_in,
  input  wire [7:0]  addr_in,
  input  wire [15:0] wdata_in,
  output reg  [15:0] rdata_out,
  output reg         rdata_valid_out,
  output reg         mode_pin_disable_out,
  output reg         sequencer_owns_io_out,
  output reg         i2c_timeout_enable_out,
  output reg         fast_serial_out_enable_out,
  output reg         serial_out_enable_out,
  output reg         sequencer_abort_out,
  output reg         sequencer_active_out,
  output reg  [7:0]  indirect_address_out,
  output reg  [29:0] linearizer_x_points_out,
  output reg  [23:0] linearizer_y_points_out
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  reg  [15:0] operating_mode_control;
  reg  [15:0] host_interface_control;
  reg  [15:0] sequencer_control;
  reg  [7:0]  indirect_address;
  wire [15:0] pmem_rdata;
  wire [29:0] x_points;
  wire [23:0] y_points;
  wire        wr_mode;
  wire        wr_host;
  wire        wr_seq;
  wire        wr_addr;
  wire        data_wr;
  wire        data_rd;
  reg  [15:0] next_rdata;
  reg  [15:0] pmem_wdata;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // write wins when both strobes are given for one access
  assign wr_mode = wr_en_in && addr_in == `OFS_OPERATING_MODE_CONTROL;
  assign wr_host = wr_en_in && addr_in == `OFS_HOST_INTERFACE_CONTROL;
  assign wr_seq  = wr_en_in && addr_in == `OFS_SEQUENCER_CONTROL;
  assign wr_addr = wr_en_in && addr_in == `OFS_INDIRECT_ADDRESS;
  assign data_wr = wr_en_in && addr_in == `OFS_INDIRECT_DATA;
  assign data_rd = !wr_en_in && rd_en_in && addr_in == `OFS_INDIRECT_DATA;

  // ------------------------------------------------------------
  // parameter memory write data
  // ------------------------------------------------------------
  // point words keep reserved bits at zero so the sequencer never sees junk
  always @* begin
    case (indirect_address)
      `PMEM_X1, `PMEM_X2, `PMEM_X3: pmem_wdata = wdata_in & `PMEM_X_MASK;
      `PMEM_Y1, `PMEM_Y2, `PMEM_Y3: pmem_wdata = wdata_in & `PMEM_Y_MASK;
      default:                      pmem_wdata = wdata_in;
    endcase
  end

  param_memory #(
    .ADDR_W (8),
    .DATA_W (16)
  ) u_param_memory (
    .clk_in    (clk_in),
    .we_in     (data_wr),
    .addr_in   (indirect_address),
    .wdata_in  (pmem_wdata),
    .rdata_out (pmem_rdata)
  );

  linearizer_points u_linearizer_points (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .we_in        (data_wr),
    .addr_in      (indirect_address),
    .wdata_in     (pmem_wdata),
    .x_points_out (x_points),
    .y_points_out (y_points)
  );

  // ------------------------------------------------------------
  // direct registers
  // ------------------------------------------------------------
  // reserved r/w fields store what is written; only the decoded bits steer logic
  always @(posedge clk_in) begin
    if (rst_in) begin
      operating_mode_control <= `RST_OPERATING_MODE_CONTROL;
      host_interface_control <= `RST_HOST_INTERFACE_CONTROL;
      sequencer_control      <= `RST_SEQUENCER_CONTROL;
    end else begin
      if (wr_mode) begin
        operating_mode_control <= wdata_in & `MASK_OPERATING_MODE_CONTROL;
      end
      if (wr_host) begin
        host_interface_control <= wdata_in & `MASK_HOST_INTERFACE_CONTROL;
      end
      if (wr_seq) begin
        sequencer_control <= wdata_in & `MASK_SEQUENCER_CONTROL;
      end
    end
  end

  // ------------------------------------------------------------
  // indirect address with auto-increment
  // ------------------------------------------------------------
  // an explicit address write in the same cycle overrides the increment
  always @(posedge clk_in) begin
    if (rst_in) begin
      indirect_address <= `RST_INDIRECT_ADDRESS;
    end else if (wr_addr) begin
      indirect_address <= wdata_in[7:0];
    end else if (data_wr || data_rd) begin
      indirect_address <= indirect_address + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped offsets read zero
  always @* begin
    case (addr_in)
      `OFS_OPERATING_MODE_CONTROL: next_rdata = operating_mode_control;
      `OFS_HOST_INTERFACE_CONTROL: next_rdata = host_interface_control;
      `OFS_SEQUENCER_CONTROL:      next_rdata = sequencer_control;
      `OFS_INDIRECT_ADDRESS:       next_rdata = {8'h00, indirect_address};
      `OFS_INDIRECT_DATA:          next_rdata = pmem_rdata;
      default:                     next_rdata = 16'h0000;
    endcase
  end

  // read answer registered one cycle after the strobe
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out       <= 16'h0000;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rd_en_in && !wr_en_in;
      if (rd_en_in && !wr_en_in) begin
        rdata_out <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // control outputs, registered from the register fields and the linearizer point shadow
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_pin_disable_out       <= 1'b0;
      sequencer_owns_io_out      <= 1'b1;
      i2c_timeout_enable_out     <= 1'b0;
      fast_serial_out_enable_out <= 1'b0;
      serial_out_enable_out      <= 1'b0;
      sequencer_abort_out        <= 1'b0;
      sequencer_active_out       <= 1'b1;
      indirect_address_out       <= 8'h00;
      linearizer_x_points_out    <= 30'h00000000;
      linearizer_y_points_out    <= 24'h000000;
    end else begin
      mode_pin_disable_out       <= operating_mode_control[`BIT_MODE_PIN_DISABLE];
      sequencer_owns_io_out      <= operating_mode_control[`BIT_SEQUENCER_OWNS_IO];
      i2c_timeout_enable_out     <= host_interface_control[`BIT_I2C_TIMEOUT_ENABLE];
      fast_serial_out_enable_out <= host_interface_control[`BIT_FAST_SERIAL_OUT_ENABLE];
      serial_out_enable_out      <= host_interface_control[`BIT_SERIAL_OUT_ENABLE];
      sequencer_abort_out        <= sequencer_control[`BIT_SEQUENCER_ABORT];
      // run without enable is held off
      sequencer_active_out       <= sequencer_control[`BIT_SEQUENCER_RUN] &
                                    sequencer_control[`BIT_SEQUENCER_ENABLE];
      indirect_address_out       <= indirect_address;
      linearizer_x_points_out    <= x_points;
      linearizer_y_points_out    <= y_points;
    end
  end
endmodule // foldback_config_regs
`default_nettype wire

// ### src/linearizer_points.v
`timescale 1ns/100ps
`default_nettype none
`include "foldback_consts.vh"
// ------------------------------------------------------------
// shadow of the linearizer points, snooped from memory writes
// ------------------------------------------------------------
module linearizer_points (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        we_in,
  input  wire [7:0]  addr_in,
  input  wire [15:0] wdata_in,
  output reg  [29:0] x_points_out,
  output reg  [23:0] y_points_out
);
  // mirror so the sequencer sees all points at once without memory ports
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_pt
      // word offset of this x/y pair from the first x word, cut to the address width
      localparam integer PAIR_OFS_I = 2 * i;
      localparam [7:0]   PAIR_OFS   = PAIR_OFS_I[7:0];
      always @(posedge clk_in) begin
        if (rst_in) begin
          x_points_out[i*10 +: 10] <= 10'h000;
          y_points_out[i*8 +: 8]   <= 8'h00;
        end else if (we_in && addr_in == (`PMEM_X1 + PAIR_OFS)) begin
          x_points_out[i*10 +: 10] <= wdata_in[10:1];
        end else if (we_in && addr_in == (`PMEM_Y1 + PAIR_OFS)) begin
          y_points_out[i*8 +: 8] <= wdata_in[7:0];
        end
      end
    end
  endgenerate
endmodule // linearizer_points
`default_nettype wire

// ### src/param_memory.v
`timescale 1ns/100ps
`default_nettype none
`include "foldback_consts.vh"
// ------------------------------------------------------------
// parameter sram, one word per location, synchronous write
// ------------------------------------------------------------
module param_memory #(
  parameter ADDR_W = 8,
  parameter DATA_W = 16
) (
  input  wire              clk_in,
  input  wire              we_in,
  input  wire [ADDR_W-1:0] addr_in,
  input  wire [DATA_W-1:0] wdata_in,
  output wire [DATA_W-1:0] rdata_out
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // asynchronous read keeps the data register answer in the same cycle
  assign rdata_out = mem[addr_in];

  // write port
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule // param_memory
`default_nettype wire

// ### verif/foldback_config_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// port checker
// ----
module foldback_config_regs_properties (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic [7:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        rdata_valid_out,
  input wire logic        mode_pin_disable_out,
  input wire logic        sequencer_owns_io_out,
  input wire logic        i2c_timeout_enable_out,
  input wire logic        fast_serial_out_enable_out,
  input wire logic        serial_out_enable_out,
  input wire logic        sequencer_abort_out,
  input wire logic        sequencer_active_out,
  input wire logic [7:0]  indirect_address_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // decoded requests; controls land two edges after the write is taken
  wire wr_mode = wr_en_in && addr_in == 8'h25;
  wire wr_host = wr_en_in && addr_in == 8'h26;
  wire wr_seq = wr_en_in && addr_in == 8'h27;
  wire wr_addr = wr_en_in && addr_in == 8'h2B;
  wire acc_data = (wr_en_in || rd_en_in) && addr_in == 8'h2C;
  wire rd_only = rd_en_in && !wr_en_in;
  logic [15:0] wd_d1;
  logic [15:0] wd_d2;
  // write data two edges back, lined up with the control output it must reach
  always @(posedge clk_in) begin
    wd_d1 <= wdata_in;
    wd_d2 <= wd_d1;
  end
  a_read_answer: assert property (rd_only |=> rdata_valid_out)
    else $error("read gave no valid pulse");
  a_valid_cause: assert property (rdata_valid_out |-> $past(rd_only))
    else $error("valid pulse without a read");
  a_mode_pin: assert property (wr_mode |-> ##2 mode_pin_disable_out == wd_d2[13])
    else $error("mode pin disable wrong");
  a_owns_io: assert property (wr_mode |-> ##2 sequencer_owns_io_out == wd_d2[6])
    else $error("io ownership wrong");
  a_host_bits: assert property (wr_host |-> ##2
    {i2c_timeout_enable_out, fast_serial_out_enable_out, serial_out_enable_out} ==
    {wd_d2[12], wd_d2[2], wd_d2[0]}) else $error("interface controls wrong");
  a_seq_abort: assert property (wr_seq |-> ##2 sequencer_abort_out == wd_d2[2])
    else $error("abort wrong");
  a_seq_active: assert property (wr_seq |-> ##2
    sequencer_active_out == (wd_d2[1] && wd_d2[0]))
    else $error("run without enable or stop ignored");
  a_addr_load: assert property (wr_addr |-> ##2 indirect_address_out == wd_d2[7:0])
    else $error("address load wrong");
  a_addr_step: assert property (acc_data |-> ##2
    indirect_address_out == $past(indirect_address_out) + 8'h01)
    else $error("address did not step by one");
  c_seq_write: cover property (wr_seq);
  c_wrap: cover property (acc_data && indirect_address_out == 8'hFF);
  c_read: cover property (rdata_valid_out);
endmodule // foldback_config_regs_properties
bind foldback_config_regs foldback_config_regs_properties foldback_config_regs_properties_i (
  .clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .rdata_valid_out(rdata_valid_out),
  .mode_pin_disable_out(mode_pin_disable_out), .sequencer_owns_io_out(sequencer_owns_io_out),
  .i2c_timeout_enable_out(i2c_timeout_enable_out),
  .fast_serial_out_enable_out(fast_serial_out_enable_out),
  .serial_out_enable_out(serial_out_enable_out), .sequencer_abort_out(sequencer_abort_out),
  .sequencer_active_out(sequencer_active_out), .indirect_address_out(indirect_address_out));
`default_nettype wire

// ### verif/foldback_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// bench top
// ----
module foldback_config_regs_tb;
  logic clk_in, rst_in, wr_en, rd_en, valid, mode, owns, tmo, fsdo, sdo, abort, active;
  logic [7:0]  addr, iaddr;
  logic [15:0] wdata, rdata, d;
  logic [29:0] xpts;
  logic [23:0] ypts;
  int error_cnt = 0;
  int checked = 0;
  logic [15:0] seq_val [4] = '{16'h0002, 16'h0001, 16'h0004, 16'h0003};
  logic [15:0] pw [6] = '{16'h0002, 16'hFF11, 16'h0004, 16'hFF22, 16'hFFFF, 16'hAB33};
  logic [15:0] pr [6] = '{16'h0002, 16'h0011, 16'h0004, 16'h0022, 16'h07FE, 16'h0033};
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  host_model host_model_i (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .valid_in(valid));
  foldback_config_regs foldback_config_regs_i (.clk_in(clk_in), .rst_in(rst_in),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
    .rdata_valid_out(valid), .mode_pin_disable_out(mode), .sequencer_owns_io_out(owns),
    .i2c_timeout_enable_out(tmo), .fast_serial_out_enable_out(fsdo),
    .serial_out_enable_out(sdo), .sequencer_abort_out(abort), .sequencer_active_out(active),
    .indirect_address_out(iaddr), .linearizer_x_points_out(xpts),
    .linearizer_y_points_out(ypts));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic ok;
    host_model_i.read_reg(a, d, ok);
    if (ok !== 1'b1) begin
      check({what, " valid"}, 32'h1, 32'h0);
      tally_and_finish();
    end else begin
      check(what, {16'h0000, exp}, {16'h0000, d});
    end
  endtask
  // controls settle one edge after the write task returns
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  initial begin
    #2000000;
    check("run length", 32'h0, 32'h1);
    tally_and_finish();
  end
  initial begin
    rst_in = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check("reset outs", 32'h21, {25'h0, mode, owns, tmo, fsdo, sdo, abort, active});
    rd_chk("mode reg", 8'h25, 16'h8040);
    rd_chk("host reg", 8'h26, 16'h0000);
    rd_chk("seq reg", 8'h27, 16'h0003);
    rd_chk("addr reg", 8'h2B, 16'h0000);
    rd_chk("unmapped", 8'h30, 16'h0000);
    $display("test reset done");
    host_model_i.write_reg(8'h27, 16'h0000);
    host_model_i.write_reg(8'h25, 16'h2000);
    settle(1);
    check("mode outs", 32'h4, {29'h0, mode, owns, active});
    rd_chk("mode back", 8'h25, 16'h2000);
    host_model_i.write_reg(8'h26, 16'hFFFF);
    settle(1);
    check("host outs", 32'h7, {29'h0, tmo, fsdo, sdo});
    rd_chk("host back", 8'h26, 16'h1005);
    // run alone, enable alone, abort alone, then run with enable; run alone must not start it
    for (int i = 0; i < 4; i++) begin
      host_model_i.write_reg(8'h27, seq_val[i]);
      settle(1);
      check("seq outs", {30'h0, seq_val[i][2], seq_val[i][1] & seq_val[i][0]},
            {30'h0, abort, active});
    end
    $display("test controls done");
    host_model_i.write_reg(8'h27, 16'h0000);
    host_model_i.write_reg(8'h2B, 16'h0020);
    for (int i = 0; i < 6; i++) host_model_i.write_reg(8'h2C, pw[i]);
    settle(2);
    check("addr after", 32'h26, {24'h0, iaddr});
    check("x points", {2'b00, 10'h3FF, 10'h002, 10'h001}, {2'b00, xpts});
    check("y points", 32'h332211, {8'h00, ypts});
    host_model_i.write_reg(8'h27, 16'h0003);
    settle(1);
    check("restart", 32'h1, {31'h0, active});
    host_model_i.write_reg(8'h2B, 16'h0020);
    for (int i = 0; i < 6; i++) rd_chk("point word", 8'h2C, pr[i]);
    $display("test points done");
    host_model_i.write_reg(8'h2B, 16'h00FF);
    host_model_i.write_reg(8'h2C, 16'hA5A5);
    host_model_i.write_reg(8'h2C, 16'h5A5A);
    settle(1);
    check("wrapped addr", 32'h01, {24'h0, iaddr});
    host_model_i.write_reg(8'h2B, 16'h00FF);
    rd_chk("top word", 8'h2C, 16'hA5A5);
    rd_chk("wrap word", 8'h2C, 16'h5A5A);
    $display("test wrap done");
    tally_and_finish();
  end
endmodule // foldback_config_regs_tb
`default_nettype wire

// ### verif/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// host model: single-edge strobes, released data shows its inverse
// ----
module host_model (
  input  wire logic        clk_in,
  output logic             wr_en_out,
  output logic             rd_en_out,
  output logic [7:0]       addr_out,
  output logic [15:0]      wdata_out,
  input  wire logic [15:0] rdata_in,
  input  wire logic        valid_in
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // memory words are only reached through the address and data registers
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  // answer is looked for in a bounded window so a dead device cannot hang us
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    d = 16'h0000;
    ok = 1'b0;
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    for (int i = 0; i < 4 && ok == 1'b0; i++) begin
      #1;
      if (valid_in === 1'b1) begin
        d = rdata_in;
        ok = 1'b1;
      end else begin
        @(posedge clk_in);
      end
    end
  endtask
endmodule // host_model
`default_nettype wire
